// ===== logic/rptsc_top.sv
// Reset entry and exit, fast park and test strap sampling.
// Assumes one 50 MHz clock; pins arrive asynchronously.
//
// Function
// - Start configuration on rising reset edge only.
// - All outputs inactive while reset is low.
// - Reset input filtered against slow edge chatter.
// - Strap pins high impedance during reset.
// - Sample straps about 1.5 us after release.
// - Drive strap pins as outputs after sample.
// - Strap sampled high selects a test mode.
// - Fast park request parks mirrors on the fifth clock after the pin falls (sync and filter).
`timescale 1ns/1ps
`include "rptsc_regs.svh"

module rptsc_top (
	input wire logic clk, // Core clock, 50 MHz.
	input wire logic rstn, // Synchronous core reset, active low.
	input wire logic power_on_reset_n, // Power-on reset pin.
	input wire logic fast_park_request_n, // Fast park pin.
	input wire logic manufacturing_test_enable, // Test enable pin.
	input wire logic internal_test_reset_n, // Internal test reset pin.
	input wire rptsc_pkg::rptsc_strap_t strap_in, // Strap pin levels.
	input wire rptsc_pkg::rptsc_strap_t test_out_data, // Test signals.
	output logic [7:0] strap_out, // Strap pin drive values.
	output logic [7:0] strap_oe, // Strap pin enables.
	output logic [7:0] test_mode_r, // Latched strap selection.
	output logic test_mode_active, // Any test mode in force.
	output logic config_start, // Pulse: start self-configuration.
	output logic config_enable, // Level: configured and running.
	output logic park_fast // Level: fast park in progress.
);
	import rptsc_pkg::*;

	// ==========================================================
	// Input synchronisers
	logic [1:0] por_sync_r;
	logic [1:0] park_sync_r;
	logic [1:0] mte_sync_r;
	logic [1:0] itr_sync_r;
	logic [7:0] strap_s1_r;
	logic [7:0] strap_s2_r;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			por_sync_r <= 2'h0;
			park_sync_r <= 2'h3;
			mte_sync_r <= 2'h0;
			itr_sync_r <= 2'h0;
		end else begin
			por_sync_r <= {por_sync_r[0], power_on_reset_n};
			park_sync_r <= {park_sync_r[0], fast_park_request_n};
			mte_sync_r <= {mte_sync_r[0], manufacturing_test_enable};
			itr_sync_r <= {itr_sync_r[0], internal_test_reset_n};
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < `RPTSC_STRAP_W; gi = gi + 1) begin : g_strap
			always_ff @(posedge clk) begin
				if (!rstn) begin
					strap_s1_r[gi] <= 1'b0;
					strap_s2_r[gi] <= 1'b0;
				end else begin
					strap_s1_r[gi] <= strap_in[gi];
					strap_s2_r[gi] <= strap_s1_r[gi];
				end
			end
		end
	endgenerate

	// ==========================================================
	// Hysteresis filter on the reset level
	// The level changes only after three equal samples in a row.
	logic [1:0] por_hist_r;
	logic por_filt_r;
	logic por_filt_d_r;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			por_hist_r <= 2'h0;
			por_filt_r <= 1'b0;
			por_filt_d_r <= 1'b0;
		end else begin
			por_hist_r <= {por_hist_r[0], por_sync_r[1]};
			if (por_hist_r == 2'h3 && por_sync_r[1]) begin
				por_filt_r <= 1'b1;
			end else if (por_hist_r == 2'h0 && !por_sync_r[1]) begin
				por_filt_r <= 1'b0;
			end
			por_filt_d_r <= por_filt_r;
		end
	end

	logic por_rise;
	assign por_rise = por_filt_r && !por_filt_d_r;

	// The park level follows only two equal synchronised samples.
	logic park_hist_r;
	logic park_filt_r;
	always_ff @(posedge clk) begin
		if (!rstn) begin
			park_hist_r <= 1'b1;
			park_filt_r <= 1'b1;
		end else begin
			park_hist_r <= park_sync_r[1];
			if (park_sync_r[1] == park_hist_r) begin
				park_filt_r <= park_sync_r[1];
			end
		end
	end

	// ==========================================================
	// Sequencer
	localparam logic [`RPTSC_CNT_W-1:0] STRAP_CNT =
		`RPTSC_CNT_W'(`RPTSC_STRAP_CYCLES);
	rptsc_state_t state_r;
	logic [`RPTSC_CNT_W-1:0] cnt_r;
	logic sample_now;

	assign sample_now = (state_r == RPTSC_ST_WAIT) && (cnt_r == STRAP_CNT);

	always_ff @(posedge clk) begin
		if (!rstn || !por_filt_r) begin
			state_r <= RPTSC_ST_RESET;
		end else begin
			unique case (state_r)
				RPTSC_ST_RESET: begin
					if (por_rise) begin
						state_r <= RPTSC_ST_WAIT;
					end
				end
				RPTSC_ST_WAIT: begin
					if (sample_now) begin
						state_r <= RPTSC_ST_RUN;
					end
				end
				RPTSC_ST_RUN: begin
					if (!park_filt_r) begin
						state_r <= RPTSC_ST_PARK;
					end
				end
				RPTSC_ST_PARK: begin
					state_r <= RPTSC_ST_PARK;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn || state_r != RPTSC_ST_WAIT) begin
			cnt_r <= `RPTSC_CNT_W'h01;
		end else begin
			cnt_r <= cnt_r + `RPTSC_CNT_W'h01;
		end
	end

	// ==========================================================
	// Strap capture and pin drive
	always_ff @(posedge clk) begin
		if (!rstn || !por_filt_r) begin
			test_mode_r <= 8'h00;
			test_mode_active <= 1'b0;
		end else if (sample_now) begin
			test_mode_r <= strap_s2_r;
			test_mode_active <= (|strap_s2_r) && mte_sync_r[1];
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn || !por_filt_r) begin
			strap_oe <= 8'h00;
			strap_out <= 8'h00;
		end else if (state_r != RPTSC_ST_WAIT && state_r != RPTSC_ST_RESET) begin
			strap_oe <= 8'hFF;
			strap_out <= test_out_data;
		end
	end

	// ==========================================================
	// Configuration and park outputs
	always_ff @(posedge clk) begin
		if (!rstn || !por_filt_r) begin
			config_start <= 1'b0;
			config_enable <= 1'b0;
			park_fast <= 1'b0;
		end else begin
			config_start <= sample_now;
			config_enable <= (state_r == RPTSC_ST_RUN) && !itr_sync_r[1];
			park_fast <= (state_r == RPTSC_ST_PARK) ||
				(state_r == RPTSC_ST_RUN && !park_filt_r);
		end
	end

	// ==========================================================
	// Checks
	a_straps_float_reset: assert property (
		@(posedge clk) disable iff (!rstn)
		!por_filt_r |=> strap_oe == 8'h00)
		else $error("Strap pins driven during reset.");
	a_sample_delay_exact: assert property (
		@(posedge clk) disable iff (!rstn)
		por_rise && state_r == RPTSC_ST_RESET |=> state_r == RPTSC_ST_WAIT
		##74 (sample_now || !por_filt_r))
		else $error("Strap sample not at 1.5 us.");
	a_drive_after_sample: assert property (
		@(posedge clk) disable iff (!rstn)
		sample_now && por_filt_r |=> ##1 (strap_oe == 8'hFF || !por_filt_r))
		else $error("Straps not driven after sample.");
	a_outputs_idle_reset: assert property (
		@(posedge clk) disable iff (!rstn)
		!por_filt_r |=> !config_enable && !park_fast && !config_start)
		else $error("Output active during reset.");
	a_start_on_rise: assert property (
		@(posedge clk) disable iff (!rstn)
		$rose(state_r == RPTSC_ST_WAIT) |-> $past(por_rise))
		else $error("Sequence started without rising edge.");
	a_fast_park_follow: assert property (
		@(posedge clk) disable iff (!rstn)
		state_r == RPTSC_ST_RUN && !park_filt_r && por_filt_r |=> park_fast)
		else $error("Fast park not raised.");
	a_test_needs_enable: assert property (
		@(posedge clk) disable iff (!rstn)
		sample_now && !mte_sync_r[1] |=> !test_mode_active)
		else $error("Test mode without enable.");
	a_test_mode_high: assert property (
		@(posedge clk) disable iff (!rstn)
		sample_now && mte_sync_r[1] && |strap_s2_r && por_filt_r
		|=> test_mode_active)
		else $error("High strap did not select test mode.");
	a_filter_steady: assert property (
		@(posedge clk) disable iff (!rstn)
		$changed(por_filt_r) |-> por_hist_r[1] == por_filt_r)
		else $error("Reset filter changed without steady samples.");
endmodule

// ===== logic/rptsc_regs.svh
// Timing constants for the reset, park and test strap controller.
// Assumes a 50 MHz core clock.
`ifndef RPTSC_REGS_SVH
`define RPTSC_REGS_SVH
`define RPTSC_CLK_PERIOD_PS 20000
`define RPTSC_STRAP_DELAY_PS 1500000
// Strap sample delay is 1.5 us, held here in nanoseconds.
`define RPTSC_STRAP_DELAY_NS 1500
`define RPTSC_STRAP_CYCLES ((`RPTSC_STRAP_DELAY_NS * 1000) / `RPTSC_CLK_PERIOD_PS)
`define RPTSC_CNT_W 7
`define RPTSC_STRAP_W 8
`endif

// ===== logic/rptsc_pkg.sv
// Types for the reset, park and test strap controller.
// Assumes rptsc_regs.svh is compiled alongside.
package rptsc_pkg;
	typedef enum logic [3:0] {
		RPTSC_ST_RESET = 4'h1,
		RPTSC_ST_WAIT = 4'h2,
		RPTSC_ST_RUN = 4'h4,
		RPTSC_ST_PARK = 4'h8
	} rptsc_state_t;
	typedef logic [7:0] rptsc_strap_t;
endpackage

// ===== bench/rptsc_strap_board.sv
// Board model of the strap pins: weak pull-downs and optional pull-ups.
// Assumes the controller's strap drive and enable outputs are connected.
`timescale 1ns/1ps
// ==========
// Strap wire
module rptsc_strap_board (
	input wire logic [7:0] strap_out, // Controller drive values.
	input wire logic [7:0] strap_oe, // Controller enables.
	input wire logic [7:0] pull_up, // Board pull-up fitted.
	output logic [7:0] strap_in // Resolved pin levels.
);
	// An undriven pin settles low unless a pull-up is fitted.
	assign strap_in = (strap_oe & strap_out) | (~strap_oe & pull_up);
endmodule

// ===== bench/reset_park_test_strap_control_tb.sv
// Self-checking bench for the reset, park and strap controller.
// Assumes the board model file is compiled first.
`timescale 1ns/1ps
module reset_park_test_strap_control_tb;
	import rptsc_pkg::*;
	logic clk = 0, rstn = 0, por_n = 0, park_n = 1, ten = 0, itr_n = 0;
	rptsc_strap_t pull = 8'h00, tdat = 8'hA5, s_in;
	logic [7:0] s_out, s_oe, tmode;
	logic act, cstart, cen, pfast;
	int n_fail = 0, check_count = 0, lat;
	rptsc_top dut (.clk(clk), .rstn(rstn), .power_on_reset_n(por_n),
		.fast_park_request_n(park_n), .manufacturing_test_enable(ten),
		.internal_test_reset_n(itr_n), .strap_in(s_in),
		.test_out_data(tdat), .strap_out(s_out), .strap_oe(s_oe),
		.test_mode_r(tmode), .test_mode_active(act),
		.config_start(cstart), .config_enable(cen), .park_fast(pfast));
	rptsc_strap_board board (.strap_out(s_out), .strap_oe(s_oe),
		.pull_up(pull), .strap_in(s_in));
	initial begin
		forever #10 clk = ~clk;
	end
	// ==========
	// Shared tasks
	task close_out;
		$display("checks %0d, mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task chk(string nm, logic [7:0] e, logic [7:0] g);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask
	task go_reset;
		@(negedge clk) por_n = 0;
		repeat (10) @(negedge clk);
	endtask
	task power_up(input rptsc_strap_t p, input logic t);
		pull = p;
		ten = t;
		go_reset();
		// Reset is released only with supplies and clock running.
		@(negedge clk) por_n = 1;
		lat = 0;
		while (cstart !== 1'b1 && lat < 200) begin
			@(negedge clk);
			lat++;
		end
		chk("start_lat", 8'h01, {7'h0, lat >= 76 && lat <= 84});
	endtask
	// ==========
	// Scenarios
	task t_reset;
		go_reset();
		chk("oe_rst", 8'h00, s_oe);
		chk("mode_rst", 8'h00, tmode);
		chk("out_rst", 8'h00, {4'h0, act, cstart, cen, pfast});
	endtask
	task t_normal;
		power_up(8'h00, 1'b1);
		chk("mode_open", 8'h00, tmode);
		chk("act_open", 8'h00, {7'h0, act});
		@(negedge clk);
		chk("oe_run", 8'hFF, s_oe);
		chk("out_run", tdat, s_out);
		chk("run", 8'h01, {6'h0, cstart, cen});
	endtask
	task t_glitch;
		int seen;
		go_reset();
		seen = 0;
		@(negedge clk) por_n = 1;
		@(negedge clk) por_n = 0;
		repeat (100) begin
			@(negedge clk) seen |= cstart;
		end
		chk("glitch", 8'h00, seen[7:0]);
	endtask
	task t_strap;
		power_up(8'h20, 1'b1);
		chk("mode_sel", 8'h20, tmode);
		chk("mode_act", 8'h01, {7'h0, act});
		power_up(8'h81, 1'b0);
		chk("mode_gate", 8'h00, {7'h0, act});
		chk("mode_lat", 8'h81, tmode);
		pull = 8'h00;
	endtask
	task t_park;
		power_up(8'h00, 1'b0);
		// Fast park stands for imminent power loss.
		@(negedge clk) park_n = 0;
		repeat (8) @(negedge clk);
		chk("park", 8'h02, {6'h0, pfast, cen});
		park_n = 1;
	endtask
	task t_itr;
		power_up(8'h00, 1'b0);
		@(negedge clk) itr_n = 1;
		repeat (3) @(negedge clk);
		chk("itr", 8'h00, {7'h0, cen});
		itr_n = 0;
	endtask
	initial begin
		#400000;
		n_fail++;
		close_out();
	end
	initial begin
		repeat (12) @(negedge clk);
		rstn = 1;
		t_reset();
		t_normal();
		t_glitch();
		t_strap();
		t_park();
		t_itr();
		close_out();
	end
endmodule
